//--- core/hci_uart_pkg.sv
// What this block does
// - Four wires: receive, transmit, RTS, CTS
// - Line rates from 57600 up to 6 Mbps
// - Host expects at most 750 kbps during boot
// - 1040-byte receive and transmit queues
// - Link carries H4 HCI byte stream
// - Default line rate is 115.2 kbaud
// - Source clock 24 MHz, selectable 48 MHz
// - Divisor divides source clock by 16 multiples, or by one multiple at the high rate
// - Up to eight stuffed cycles per half bit
// - Baud settings loaded from post-reset configuration record
// - Host command rewrites baud settings while running
// - Combined rate error within two percent
// - 24 MHz, 0xFF/0xF8 high rate gives 3M
// - 48 MHz: 0xFF/0xF8 gives 6M, 0xF4 4M
`default_nettype none
package hci_uart_pkg;
   localparam int FIFO_DEPTH = 1040;
   localparam int RTS_MARGIN = 2;
   localparam int FRAME_LAST_BIT = 9;
   localparam logic [7:0] DIV_RST = 8'hf3;
   localparam logic [7:0] ADJ_RST = 8'h00;
   localparam logic CLK48_RST = 1'b0;
   localparam logic [7:0] ADJ_HIGH_RATE = 8'hff;
   localparam logic [3:0] MAX_STUFF = 4'h8;
   localparam int HALF_SHIFT = 3;
   localparam logic [7:0] OFF_BAUD = 8'h00;
   localparam logic [7:0] OFF_TXDATA = 8'h04;
   localparam logic [7:0] OFF_RXDATA = 8'h08;
   localparam logic [7:0] OFF_STATUS = 8'h0c;
   localparam int BAUD_DIV_LSB = 0;
   localparam int BAUD_ADJ_LSB = 8;
   localparam int RXDATA_VALID_BIT = 8;
   localparam int ST_TX_READY = 0;
   localparam int ST_RX_VALID = 1;
   localparam int ST_TX_BUSY = 2;
   localparam int ST_CTS = 3;

   typedef logic [12:0] cyc_t;

   // Cycles in one half of a bit; each half is 8 steps so a bit is 16 steps, except at the high rate where a whole bit is one step
   function automatic cyc_t half_cycles(input logic [7:0] div, input logic [7:0] adj, input logic second);
      cyc_t steps;
      cyc_t res;
      logic [3:0] stuff;
      steps = cyc_t'(9'h100 - {1'b0, div});
      stuff = second ? adj[3:0] : adj[7:4];
      if (stuff > MAX_STUFF) begin
         stuff = MAX_STUFF;
      end
      if (adj == ADJ_HIGH_RATE) begin
         res = second ? steps - (steps >> 1) : (steps >> 1);
      end else begin
         res = (steps << HALF_SHIFT) + cyc_t'(stuff);
      end
      if (res == '0) begin
         res = cyc_t'(1);
      end
      return res;
   endfunction
endpackage
`default_nettype wire

//--- core/hci_link_if.sv
`default_nettype none
interface hci_link_if;
   logic h2d_txd;
   logic d2h_txd;
   logic host_rts_n;
   logic dev_rts_n;
   modport device(input h2d_txd, input host_rts_n, output d2h_txd, output dev_rts_n);
   modport host(output h2d_txd, output host_rts_n, input d2h_txd, input dev_rts_n);
endinterface
`default_nettype wire

//--- core/two_entry_buf.sv
`default_nettype none
module two_entry_buf #(
   parameter int W = 8
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [W-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [W-1:0] out_data
);
   typedef struct packed {
      logic [W-1:0] data0;
      logic [W-1:0] data1;
      logic v0;
      logic v1;
   } buf_t;

   buf_t q;
   buf_t d;

   if (W < 1) begin : g_chk
      $error("two_entry_buf: W must be at least 1");
   end

   always_comb begin
      d = q;
      if (q.v0 && out_ready) begin
         d.data0 = q.data1;
         d.v0 = q.v1;
         d.v1 = 1'b0;
      end
      if (in_valid && !q.v1) begin
         if (!d.v0) begin
            d.data0 = in_data;
            d.v0 = 1'b1;
         end else begin
            d.data1 = in_data;
            d.v1 = 1'b1;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign in_ready = !q.v1;
   assign out_valid = q.v0;
   assign out_data = q.data0;
endmodule
`default_nettype wire

//--- core/hci_uart_device.sv
`default_nettype none
module hci_uart_device #(
   parameter int DEPTH = hci_uart_pkg::FIFO_DEPTH
) (
   input wire logic pclk,
   input wire logic presetn,
   hci_link_if.device link,
   input wire logic cfg_load,
   input wire logic [7:0] cfg_divisor,
   input wire logic [7:0] cfg_adjust,
   input wire logic cfg_clk48,
   output logic uart_clk_sel,
   input wire logic tx_valid,
   output logic tx_ready,
   input wire logic [7:0] tx_data,
   output logic rx_valid,
   input wire logic rx_ready,
   output logic [7:0] rx_data,
   output logic tx_busy,
   output logic rx_frame_err,
   output logic rx_overrun
);
   localparam int AW = $clog2(DEPTH);
   localparam int CW = $clog2(DEPTH + 1);
   localparam logic [AW-1:0] LAST_PTR = AW'(DEPTH - 1);
   localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);
   localparam logic [CW-1:0] RTS_CNT = CW'(DEPTH - hci_uart_pkg::RTS_MARGIN);

   typedef enum logic [0:0] {TX_IDLE, TX_RUN} tx_state_t;
   typedef enum logic [0:0] {RX_IDLE, RX_RUN} rx_state_t;

   typedef struct packed {
      logic [7:0] baud_divisor_field;
      logic [7:0] baud_adjust_field;
      logic clk48;
      logic rx_s1;
      logic rx_s2;
      logic cts_s1;
      logic cts_s2;
      tx_state_t tx_state;
      hci_uart_pkg::cyc_t tx_cnt;
      logic tx_half;
      logic [3:0] tx_bit;
      logic [9:0] tx_shift;
      logic txd;
      rx_state_t rx_state;
      hci_uart_pkg::cyc_t rx_cnt;
      logic [3:0] rx_bit;
      logic [7:0] rx_shift;
      logic [AW-1:0] twr;
      logic [AW-1:0] trd;
      logic [CW-1:0] tcount;
      logic [AW-1:0] rwr;
      logic [AW-1:0] rrd;
      logic [CW-1:0] rcount;
      logic rts_n;
      logic tx_ready;
      logic frame_err;
      logic overrun;
   } st_t;

   localparam st_t ST_RST = '{
      baud_divisor_field: hci_uart_pkg::DIV_RST,
      baud_adjust_field: hci_uart_pkg::ADJ_RST,
      clk48: hci_uart_pkg::CLK48_RST,
      rx_s1: 1'b1,
      rx_s2: 1'b1,
      cts_s1: 1'b1,
      cts_s2: 1'b1,
      tx_state: TX_IDLE,
      rx_state: RX_IDLE,
      txd: 1'b1,
      rts_n: 1'b1,
      default: '0
   };

   if (DEPTH < 4) begin : g_chk
      $error("hci_uart_device: DEPTH must be at least 4");
   end

   st_t q;
   st_t d;
   logic [7:0] tx_mem [DEPTH];
   logic [7:0] rx_mem [DEPTH];
   logic tx_push;
   logic tx_pop;
   logic rx_push;
   logic rx_pop;
   logic buf_in_ready;
   hci_uart_pkg::cyc_t h1;
   hci_uart_pkg::cyc_t h2;

   // Stuffing is applied to live settings, so a rate change lands on the next count loaded: next half bit on transmit, next bit on receive
   assign h1 = hci_uart_pkg::half_cycles(q.baud_divisor_field, q.baud_adjust_field, 1'b0);
   assign h2 = hci_uart_pkg::half_cycles(q.baud_divisor_field, q.baud_adjust_field, 1'b1);

   always_comb begin
      d = q;
      tx_pop = 1'b0;
      rx_push = 1'b0;
      d.rx_s1 = link.h2d_txd;
      d.rx_s2 = q.rx_s1;
      d.cts_s1 = link.host_rts_n;
      d.cts_s2 = q.cts_s1;
      // Same port serves the boot record and the host's vendor rate command
      if (cfg_load) begin
         d.baud_divisor_field = cfg_divisor;
         d.baud_adjust_field = cfg_adjust;
         d.clk48 = cfg_clk48;
      end
      tx_push = tx_valid && q.tx_ready;
      case (q.tx_state)
         TX_IDLE: begin
            // CTS is only checked between characters; a started frame always completes
            if (q.tcount != '0 && !q.cts_s2) begin
               d.tx_shift = {1'b1, tx_mem[q.trd], 1'b0};
               d.txd = 1'b0;
               d.tx_cnt = h1 - 1'b1;
               d.tx_half = 1'b0;
               d.tx_bit = '0;
               d.tx_state = TX_RUN;
               tx_pop = 1'b1;
            end
         end
         TX_RUN: begin
            if (q.tx_cnt != '0) begin
               d.tx_cnt = q.tx_cnt - 1'b1;
            end else if (!q.tx_half) begin
               d.tx_half = 1'b1;
               d.tx_cnt = h2 - 1'b1;
            end else if (q.tx_bit == 4'(hci_uart_pkg::FRAME_LAST_BIT)) begin
               d.tx_state = TX_IDLE;
            end else begin
               d.tx_shift = {1'b1, q.tx_shift[9:1]};
               d.txd = q.tx_shift[1];
               d.tx_bit = q.tx_bit + 1'b1;
               d.tx_half = 1'b0;
               d.tx_cnt = h1 - 1'b1;
            end
         end
         default: begin
            d.tx_state = TX_IDLE;
         end
      endcase
      case (q.rx_state)
         RX_IDLE: begin
            if (!q.rx_s2) begin
               d.rx_cnt = h1 - 1'b1;
               d.rx_bit = '0;
               d.rx_state = RX_RUN;
            end
         end
         RX_RUN: begin
            // Sampling at the centre of each bit leaves margin for the summed rate error
            if (q.rx_cnt != '0) begin
               d.rx_cnt = q.rx_cnt - 1'b1;
            end else if (q.rx_bit == '0 && q.rx_s2) begin
               d.rx_state = RX_IDLE;
            end else if (q.rx_bit == 4'(hci_uart_pkg::FRAME_LAST_BIT)) begin
               d.rx_state = RX_IDLE;
               if (!q.rx_s2) begin
                  d.frame_err = 1'b1;
               end else if (q.rcount == FULL_CNT) begin
                  d.overrun = 1'b1;
               end else begin
                  rx_push = 1'b1;
               end
            end else begin
               if (q.rx_bit != '0) begin
                  d.rx_shift = {q.rx_s2, q.rx_shift[7:1]};
               end
               d.rx_bit = q.rx_bit + 1'b1;
               d.rx_cnt = h2 + h1 - 1'b1;
            end
         end
         default: begin
            d.rx_state = RX_IDLE;
         end
      endcase
      rx_pop = (q.rcount != '0) && buf_in_ready;
      if (tx_push) begin
         d.twr = (q.twr == LAST_PTR) ? '0 : q.twr + 1'b1;
      end
      if (tx_pop) begin
         d.trd = (q.trd == LAST_PTR) ? '0 : q.trd + 1'b1;
      end
      if (rx_push) begin
         d.rwr = (q.rwr == LAST_PTR) ? '0 : q.rwr + 1'b1;
      end
      if (rx_pop) begin
         d.rrd = (q.rrd == LAST_PTR) ? '0 : q.rrd + 1'b1;
      end
      d.tcount = q.tcount + CW'(tx_push) - CW'(tx_pop);
      d.rcount = q.rcount + CW'(rx_push) - CW'(rx_pop);
      d.tx_ready = d.tcount != FULL_CNT;
      // Margin covers a character already in flight when RTS rises
      d.rts_n = d.rcount >= RTS_CNT;
   end

   always_ff @(posedge pclk) begin
      if (tx_push) begin
         tx_mem[q.twr] <= tx_data;
      end
      if (rx_push) begin
         rx_mem[q.rwr] <= q.rx_shift;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         q <= ST_RST;
      end else begin
         q <= d;
      end
   end

   two_entry_buf #(.W(8)) u_rx_buf (
      .pclk(pclk),
      .presetn(presetn),
      .in_valid(rx_pop),
      .in_ready(buf_in_ready),
      .in_data(rx_mem[q.rrd]),
      .out_valid(rx_valid),
      .out_ready(rx_ready),
      .out_data(rx_data)
   );

   assign link.d2h_txd = q.txd;
   assign link.dev_rts_n = q.rts_n;
   assign uart_clk_sel = q.clk48;
   assign tx_ready = q.tx_ready;
   assign tx_busy = q.tx_state == TX_RUN;
   assign rx_frame_err = q.frame_err;
   assign rx_overrun = q.overrun;
endmodule
`default_nettype wire

//--- core/hci_uart_host.sv
`default_nettype none
module hci_uart_host (
   input wire logic pclk,
   input wire logic presetn,
   hci_link_if.host link,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr
);
   typedef enum logic [0:0] {H_IDLE, H_RUN} h_state_t;

   typedef struct packed {
      logic [7:0] div;
      logic [7:0] adj;
      logic rx_s1;
      logic rx_s2;
      logic cts_s1;
      logic cts_s2;
      h_state_t tx_state;
      hci_uart_pkg::cyc_t tx_cnt;
      logic tx_half;
      logic [3:0] tx_bit;
      logic [9:0] tx_shift;
      logic txd;
      h_state_t rx_state;
      hci_uart_pkg::cyc_t rx_cnt;
      logic [3:0] rx_bit;
      logic [7:0] rx_shift;
      logic rts_n;
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
   } st_t;

   localparam st_t ST_RST = '{
      div: hci_uart_pkg::DIV_RST,
      adj: hci_uart_pkg::ADJ_RST,
      rx_s1: 1'b1,
      rx_s2: 1'b1,
      cts_s1: 1'b1,
      cts_s2: 1'b1,
      tx_state: H_IDLE,
      rx_state: H_IDLE,
      txd: 1'b1,
      rts_n: 1'b1,
      default: '0
   };

   st_t q;
   st_t d;
   logic acc;
   logic txb_in_ready;
   logic txb_valid;
   logic txb_pop;
   logic [7:0] txb_data;
   logic rxb_in_ready;
   logic rxb_valid;
   logic rxb_push;
   logic rxb_pop;
   logic [7:0] rxb_data;
   logic wr_tx;
   hci_uart_pkg::cyc_t h1;
   hci_uart_pkg::cyc_t h2;

   assign h1 = hci_uart_pkg::half_cycles(q.div, q.adj, 1'b0);
   assign h2 = hci_uart_pkg::half_cycles(q.div, q.adj, 1'b1);
   assign acc = psel && penable && q.pready;
   assign wr_tx = acc && pwrite && paddr == hci_uart_pkg::OFF_TXDATA;
   // Pop only a byte the setup cycle reported; one landing meanwhile waits for the next read
   assign rxb_pop = acc && !pwrite && paddr == hci_uart_pkg::OFF_RXDATA && q.prdata[hci_uart_pkg::RXDATA_VALID_BIT];

   always_comb begin
      d = q;
      txb_pop = 1'b0;
      rxb_push = 1'b0;
      d.rx_s1 = link.d2h_txd;
      d.rx_s2 = q.rx_s1;
      d.cts_s1 = link.dev_rts_n;
      d.cts_s2 = q.cts_s1;
      d.pready = psel && !penable;
      d.pslverr = 1'b0;
      if (psel && !penable) begin
         d.prdata = '0;
         case (paddr)
            hci_uart_pkg::OFF_BAUD: d.prdata = {16'h0000, q.adj, q.div};
            hci_uart_pkg::OFF_TXDATA: d.prdata = '0;
            hci_uart_pkg::OFF_RXDATA: d.prdata = {23'h000000, rxb_valid, rxb_data};
            hci_uart_pkg::OFF_STATUS: d.prdata = {28'h0000000, !q.cts_s2, q.tx_state == H_RUN, rxb_valid, txb_in_ready};
            default: d.pslverr = 1'b1;
         endcase
      end
      // Host must keep to 750 kbps or less until the device has booted
      if (acc && pwrite && paddr == hci_uart_pkg::OFF_BAUD) begin
         d.div = pwdata[hci_uart_pkg::BAUD_DIV_LSB +: 8];
         d.adj = pwdata[hci_uart_pkg::BAUD_ADJ_LSB +: 8];
      end
      case (q.tx_state)
         H_IDLE: begin
            if (txb_valid && !q.cts_s2) begin
               d.tx_shift = {1'b1, txb_data, 1'b0};
               d.txd = 1'b0;
               d.tx_cnt = h1 - 1'b1;
               d.tx_half = 1'b0;
               d.tx_bit = '0;
               d.tx_state = H_RUN;
               txb_pop = 1'b1;
            end
         end
         H_RUN: begin
            if (q.tx_cnt != '0) begin
               d.tx_cnt = q.tx_cnt - 1'b1;
            end else if (!q.tx_half) begin
               d.tx_half = 1'b1;
               d.tx_cnt = h2 - 1'b1;
            end else if (q.tx_bit == 4'(hci_uart_pkg::FRAME_LAST_BIT)) begin
               d.tx_state = H_IDLE;
            end else begin
               d.tx_shift = {1'b1, q.tx_shift[9:1]};
               d.txd = q.tx_shift[1];
               d.tx_bit = q.tx_bit + 1'b1;
               d.tx_half = 1'b0;
               d.tx_cnt = h1 - 1'b1;
            end
         end
         default: d.tx_state = H_IDLE;
      endcase
      case (q.rx_state)
         H_IDLE: begin
            if (!q.rx_s2) begin
               d.rx_cnt = h1 - 1'b1;
               d.rx_bit = '0;
               d.rx_state = H_RUN;
            end
         end
         H_RUN: begin
            if (q.rx_cnt != '0) begin
               d.rx_cnt = q.rx_cnt - 1'b1;
            end else if (q.rx_bit == '0 && q.rx_s2) begin
               d.rx_state = H_IDLE;
            end else if (q.rx_bit == 4'(hci_uart_pkg::FRAME_LAST_BIT)) begin
               d.rx_state = H_IDLE;
               rxb_push = q.rx_s2;
            end else begin
               if (q.rx_bit != '0) begin
                  d.rx_shift = {q.rx_s2, q.rx_shift[7:1]};
               end
               d.rx_bit = q.rx_bit + 1'b1;
               d.rx_cnt = h2 + h1 - 1'b1;
            end
         end
         default: d.rx_state = H_IDLE;
      endcase
      // One occupied slot raises RTS; the spare slot takes a character in flight
      d.rts_n = rxb_valid;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         q <= ST_RST;
      end else begin
         q <= d;
      end
   end

   two_entry_buf #(.W(8)) u_tx_buf (
      .pclk(pclk),
      .presetn(presetn),
      .in_valid(wr_tx),
      .in_ready(txb_in_ready),
      .in_data(pwdata[7:0]),
      .out_valid(txb_valid),
      .out_ready(txb_pop),
      .out_data(txb_data)
   );

   two_entry_buf #(.W(8)) u_rx_buf (
      .pclk(pclk),
      .presetn(presetn),
      .in_valid(rxb_push),
      .in_ready(rxb_in_ready),
      .in_data(q.rx_shift),
      .out_valid(rxb_valid),
      .out_ready(rxb_pop),
      .out_data(rxb_data)
   );

   assign link.h2d_txd = q.txd;
   assign link.host_rts_n = q.rts_n;
   assign prdata = q.prdata;
   assign pready = q.pready;
   assign pslverr = q.pslverr;
endmodule
`default_nettype wire

//--- tb/hci_uart_link_asserts.sv
`default_nettype none
module line_frame_track #(
   parameter int BIT = 8
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic line,
   output logic in_frame,
   output int pos
);
   timeunit 1ns;
   timeprecision 1ns;
   logic busy_q;
   int cnt_q;
   // A frame begins at the first low sample of an idle line and lasts ten bit times
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         busy_q <= 1'b0;
         cnt_q <= 0;
      end else if (in_frame && pos == 10 * BIT - 1) begin
         busy_q <= 1'b0;
         cnt_q <= 0;
      end else if (in_frame) begin
         busy_q <= 1'b1;
         cnt_q <= pos + 1;
      end
   end
   assign in_frame = busy_q || !line;
   assign pos = busy_q ? cnt_q : 0;
endmodule

module hci_uart_link_asserts #(
   parameter int BIT = 8
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic h2d_txd,
   input wire logic d2h_txd,
   input wire logic host_rts_n,
   input wire logic dev_rts_n
);
   timeunit 1ns;
   timeprecision 1ns;
   logic d_in, h_in;
   int d_pos, h_pos;
   line_frame_track #(.BIT(BIT)) d_trk (.pclk(pclk), .presetn(presetn), .line(d2h_txd), .in_frame(d_in), .pos(d_pos));
   line_frame_track #(.BIT(BIT)) h_trk (.pclk(pclk), .presetn(presetn), .line(h2d_txd), .in_frame(h_in), .pos(h_pos));
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // Bit period is fixed, so the whole frame is checked against one figure
   a_d2h_start_low: assert property (d_in && d_pos < BIT |-> !d2h_txd)
      else $error("device start bit not low for a full bit");
   a_d2h_stop_high: assert property (d_in && d_pos >= 9 * BIT |-> d2h_txd)
      else $error("device stop bit not high");
   a_d2h_bit_steady: assert property (d_in && d_pos % BIT != 0 |-> $stable(d2h_txd))
      else $error("device line changed inside a bit");
   a_d2h_idle_gap: assert property (d_in && d_pos == 10 * BIT - 1 |=> d2h_txd)
      else $error("device line not idle after stop");
   a_h2d_start_low: assert property (h_in && h_pos == 1 |-> !h2d_txd [*7])
      else $error("host start bit not low for a full bit");
   a_h2d_stop_high: assert property (h_in && h_pos == 9 * BIT |->
      h2d_txd throughout (##[0:7] h_pos == 10 * BIT - 1))
      else $error("host stop bit not high");
   a_h2d_bit_steady: assert property (h_in && h_pos % BIT != 0 |-> h2d_txd == $past(h2d_txd))
      else $error("host line changed inside a bit");
   a_cts_holds_device: assert property (host_rts_n [*5] |=> !(d_in && d_pos == 0))
      else $error("device started a character while host not ready");
   a_cts_holds_host: assert property (dev_rts_n [*5] |=> !(h_in && h_pos == 0))
      else $error("host started a character while device not ready");
   a_idle_after_reset: assert property ($rose(presetn) |-> d2h_txd && h2d_txd ##1 !dev_rts_n && !host_rts_n)
      else $error("lines not idle and ready after reset");
   c_device_frame: cover property (d_in && d_pos == 10 * BIT - 1);
   c_host_frame: cover property (h_in && h_pos == 10 * BIT - 1);
   c_device_stall: cover property ($rose(dev_rts_n));
   c_host_stall: cover property ($rose(host_rts_n));
endmodule
`default_nettype wire

//--- tb/hci_uart_fractional_baud_test.sv
`default_nettype none
module hci_uart_fractional_baud_test;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int BIT = 8;
   logic pclk = 1'b0, presetn = 1'b0, cfg_load = 1'b0, cfg_clk48 = 1'b0, tx_valid = 1'b0, rx_ready = 1'b0;
   logic [7:0] cfg_divisor = 8'h00, cfg_adjust = 8'h00, tx_data = 8'h00, paddr = 8'h00, rx_data;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, err;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic uart_clk_sel, tx_ready, rx_valid, tx_busy, rx_frame_err, rx_overrun, pready, pslverr;
   int num_errors = 0, num_checks = 0, cycles = 0, sent, got;
   hci_link_if link();
   hci_uart_device #(.DEPTH(4)) hci_uart_device_i (.pclk(pclk), .presetn(presetn), .link(link.device),
      .cfg_load(cfg_load), .cfg_divisor(cfg_divisor), .cfg_adjust(cfg_adjust), .cfg_clk48(cfg_clk48),
      .uart_clk_sel(uart_clk_sel), .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data),
      .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_data(rx_data), .tx_busy(tx_busy),
      .rx_frame_err(rx_frame_err), .rx_overrun(rx_overrun));
   hci_uart_host hci_uart_host_i (.pclk(pclk), .presetn(presetn), .link(link.host), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr));
   hci_uart_link_asserts #(.BIT(BIT)) hci_uart_link_asserts_i (.pclk(pclk), .presetn(presetn),
      .h2d_txd(link.h2d_txd), .d2h_txd(link.d2h_txd), .host_rts_n(link.host_rts_n), .dev_rts_n(link.dev_rts_n));
   always #25 pclk = ~pclk;

   task automatic report_and_stop();
      $display("Checks %0d, mismatches %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   // Generous ceiling: the longest wait is a few frames of 80 cycles plus polling
   always @(posedge pclk) begin
      cycles <= cycles + 1;
      if (cycles == 40000) begin
         num_errors++;
         $display("Error run length expected below 40000 seen %0d", cycles);
         report_and_stop();
      end
   end

   task automatic check_word(input string what, input logic [31:0] exp, input logic [31:0] seen);
      num_checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic check_bit(input string what, input logic exp, input logic seen);
      check_word(what, {31'h0, exp}, {31'h0, seen});
   endtask

   // Called right after a rising edge; ends one idle cycle later so psel is never set twice at one edge
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rdat,
                      output logic perr);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      // Only the run ceiling ends a wait for the slave
      while (pready !== 1'b1) begin
         @(posedge pclk);
      end
      rdat = prdata;
      perr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask

   task automatic poll(input logic [7:0] a, input int bitn);
      int n;
      n = 0;
      rd = 32'h0;
      while (rd[bitn] !== 1'b1 && n < 3000) begin
         apb(1'b0, a, 32'h0, rd, err);
         n++;
      end
      check_bit("status poll", 1'b1, rd[bitn]);
   endtask

   // Samples one character in mid-bit on the chosen wire
   task automatic watch_frame(input logic from_host, input logic [7:0] exp);
      logic [9:0] bits;
      int n;
      n = 0;
      @(negedge pclk);
      while ((from_host ? link.h2d_txd : link.d2h_txd) !== 1'b0 && n < 5000) begin
         n++;
         @(negedge pclk);
      end
      repeat (BIT / 2) @(negedge pclk);
      for (int i = 0; i < 10; i++) begin
         bits[i] = from_host ? link.h2d_txd : link.d2h_txd;
         repeat (BIT) @(negedge pclk);
      end
      check_word("frame bits", {22'h0, 1'b1, exp, 1'b0}, {22'h0, bits});
   endtask

   initial begin
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      repeat (2) @(posedge pclk);
      check_bit("idle d2h", 1'b1, link.d2h_txd);
      check_bit("idle h2d", 1'b1, link.h2d_txd);
      apb(1'b0, hci_uart_pkg::OFF_BAUD, 32'h0, rd, err);
      check_word("baud reset", 32'h000000f3, rd);
      check_bit("baud err", 1'b0, err);
      apb(1'b0, hci_uart_pkg::OFF_STATUS, 32'h0, rd, err);
      check_word("status reset", 32'h00000009, rd);
      apb(1'b0, hci_uart_pkg::OFF_RXDATA, 32'h0, rd, err);
      check_bit("rx empty", 1'b0, rd[8]);
      apb(1'b1, 8'h10, 32'h0, rd, err);
      check_bit("unmapped err", 1'b1, err);
      cfg_divisor <= 8'hf8;
      cfg_adjust <= 8'hff;
      cfg_clk48 <= 1'b1;
      cfg_load <= 1'b1;
      @(posedge pclk);
      cfg_load <= 1'b0;
      repeat (2) @(posedge pclk);
      check_bit("clock select", 1'b1, uart_clk_sel);
      // Host leaves the boot rate only once the device holds its record
      apb(1'b1, hci_uart_pkg::OFF_BAUD, 32'h0000fff8, rd, err);
      apb(1'b0, hci_uart_pkg::OFF_BAUD, 32'h0, rd, err);
      check_word("baud high rate", 32'h0000fff8, rd);
      $display("test registers done");
      // Host never reads, so its rts stalls the device; the tx queue fills before that and must refuse
      fork
         watch_frame(1'b0, 8'h40);
         begin
            tx_valid <= 1'b1;
            tx_data <= 8'h40;
            sent = 0;
            repeat (12) begin
               @(posedge pclk);
               if (tx_ready === 1'b1) begin
                  sent++;
                  tx_data <= 8'h40 + 8'(sent);
               end
            end
            // First character is still on the wire, so nothing has left the full queue
            check_bit("tx queue full", 1'b0, tx_ready);
            check_bit("tx busy", 1'b1, tx_busy);
            tx_valid <= 1'b0;
         end
      join
      check_bit("tx queue size", 1'b1, sent >= 4 && sent <= 6);
      for (int i = 0; i < sent; i++) begin
         poll(hci_uart_pkg::OFF_STATUS, hci_uart_pkg::ST_RX_VALID);
         check_bit("host rts", 1'b1, link.host_rts_n);
         apb(1'b0, hci_uart_pkg::OFF_RXDATA, 32'h0, rd, err);
         check_word("host rx byte", {23'h0, 1'b1, 8'h40 + 8'(i)}, rd & 32'h1ff);
      end
      $display("test device to host done");
      fork
         watch_frame(1'b1, 8'hc0);
         for (int i = 0; i < 4; i++) begin
            poll(hci_uart_pkg::OFF_STATUS, hci_uart_pkg::ST_TX_READY);
            apb(1'b1, hci_uart_pkg::OFF_TXDATA, {24'h0, 8'hc0 + 8'(i)}, rd, err);
         end
      join
      got = 0;
      while (link.dev_rts_n !== 1'b1 && got < 2000) begin
         @(posedge pclk);
         got++;
      end
      check_bit("device rts", 1'b1, link.dev_rts_n);
      rx_ready <= 1'b1;
      got = 0;
      for (int n = 0; n < 3000 && got < 4; n++) begin
         @(posedge pclk);
         if (rx_valid === 1'b1) begin
            check_word("device rx byte", {24'h0, 8'hc0 + 8'(got)}, {24'h0, rx_data});
            got++;
         end
      end
      check_word("device rx count", 32'h4, 32'(got));
      repeat (4) @(posedge pclk);
      check_bit("device rts free", 1'b0, link.dev_rts_n);
      check_bit("frame error", 1'b0, rx_frame_err);
      check_bit("overrun", 1'b0, rx_overrun);
      check_bit("tx idle", 1'b0, tx_busy);
      $display("test host to device done");
      report_and_stop();
   end
endmodule
`default_nettype wire
